// ===== tb/cic_chk_asserts.sv
// checker for the core interrupt control block, bound to its top ports
// assumes the master offers write address and data together
module cic_chk
	import cic_pkg::*;
#(
	parameter int PIN_W = 8
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer_overflow_evt,
	input wire logic external_pin_evt,
	input wire logic [PIN_W-1:0] pin_change_evt,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] core_sh_ff;
	logic [7:0] nxt_core_sh;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// shadow of the core enables; misses a write whose channels are taken on different edges
	always_comb
	begin
		nxt_core_sh = core_sh_ff;
		if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == CIC_OFF_CORE)
			nxt_core_sh = s_axi_wdata[7:0];
	end
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
			core_sh_ff <= CIC_RST_BYTE;
		else
			core_sh_ff <= nxt_core_sh;
	a_reset_outputs_low: assert property ($fell(sys_rst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not low after reset");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
		else $error("read not answered next cycle");
	a_irq_needs_gie: assert property ((!core_sh_ff[CIC_B_GIE])[*4] |-> !irq)
		else $error("irq with global enable off");
	a_timer_irq: assert property (timer_overflow_evt && core_sh_ff[7] && core_sh_ff[5] |-> ##2 irq)
		else $error("timer event gave no irq");
	a_ext_pin_irq: assert property (external_pin_evt && core_sh_ff[7] && core_sh_ff[4] |-> ##2 irq)
		else $error("external event gave no irq");
	a_pin_change_irq: assert property (|pin_change_evt && core_sh_ff[7] && core_sh_ff[3] |-> ##2 irq)
		else $error("pin change gave no irq");
	c_irq: cover property (irq);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // cic_chk

// ===== tb/cic_src_model.sv
// event source model driving the interrupt event inputs
// assumes pulse gets timer, external, pin-change, periph one to three, packed
module cic_src_model
(
	input wire logic mclk,
	output logic timer_overflow_evt,
	output logic external_pin_evt,
	output logic [7:0] pin_change_evt,
	output logic [7:0] periph_evt_one,
	output logic [7:0] periph_evt_two,
	output logic [7:0] periph_evt_three
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [33:0] evt = 34'h0;
	// one-cycle pulses launched just after an edge, like a real synchronous source
	assign {timer_overflow_evt, external_pin_evt, pin_change_evt, periph_evt_one, periph_evt_two, periph_evt_three} = evt;
	task automatic pulse(input logic [33:0] v);
		@(posedge mclk);
		evt <= v;
		@(posedge mclk);
		evt <= 34'h0;
	endtask
endmodule // cic_src_model

// ===== tb/test_core_interrupt_control.sv
// bench for the core interrupt control block: registers over axi4-lite, events from the source model
// assumes the checker is bound below and the model drives every event input
module test_core_interrupt_control
	import cic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'h0;
	logic sys_rst = 1'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire logic timer_overflow_evt, external_pin_evt;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [7:0] pin_change_evt, periph_evt_one, periph_evt_two, periph_evt_three;
	int error_cnt = 0;
	int checks_done = 0;
	cic_core u_dut (.*);
	cic_src_model u_src (.*);
	// 25 ns system clock
	always #12.5 mclk = ~mclk;
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// each task opens on a fresh edge so no signal is assigned twice in one step
	// no cycle count is assumed: only the watchdog ends a wait that never gets its answer
	task automatic axi_wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge mclk);
			if (s_axi_awready === 1'h1)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk("bresp", {30'h0, CIC_RESP_OKAY}, {30'h0, s_axi_bresp});
	endtask
	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge mclk);
			if (s_axi_arready === 1'h1)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(nm, {24'h000000, e}, d);
	endtask
	// event to irq takes two edges; four leaves margin
	task automatic settle();
		repeat (4) @(posedge mclk);
	endtask
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rd_chk("core", CIC_OFF_CORE, 8'h00);
		rd_chk("pfl1", CIC_OFF_PFL1, 8'h00);
		axi_rd(5'h01, d, r);
		chk("rresp", {30'h0, CIC_RESP_SLVERR}, {30'h0, r});
	endtask
	// global enable on but source enables off: flags still set, no irq
	task automatic t_flags();
		axi_wr(CIC_OFF_CORE, 8'h80);
		u_src.pulse({2'h3, 8'h08, 24'h0});
		settle();
		chk("irq", 32'h0, {31'h0, irq});
		rd_chk("core", CIC_OFF_CORE, 8'h87);
		axi_wr(CIC_OFF_CORE, 8'h81);
		rd_chk("core", CIC_OFF_CORE, 8'h81);
		axi_wr(CIC_OFF_PINF, 8'h00);
		rd_chk("core", CIC_OFF_CORE, 8'h80);
	endtask
	// each core source alone raises irq; dropping global enable removes it
	task automatic t_src();
		logic [7:0] en [3] = '{8'hA0, 8'h90, 8'h88};
		logic [7:0] fl [3] = '{8'h04, 8'h02, 8'h01};
		logic [33:0] ev [3] = '{{2'h2, 32'h0}, {2'h1, 32'h0}, {2'h0, 8'h80, 24'h0}};
		for (int i = 0; i < 3; i++)
		begin
			axi_wr(CIC_OFF_CORE, en[i]);
			u_src.pulse(ev[i]);
			settle();
			chk("irq on", 32'h1, {31'h0, irq});
			rd_chk("core", CIC_OFF_CORE, en[i] | fl[i]);
			axi_wr(CIC_OFF_CORE, (en[i] | fl[i]) & 8'h7F);
			settle();
			chk("irq off", 32'h0, {31'h0, irq});
			axi_wr(CIC_OFF_CORE, 8'h00);
			axi_wr(CIC_OFF_PINF, 8'h00);
		end
	endtask
	task automatic t_periph();
		axi_wr(CIC_OFF_PEN1, 8'hFF);
		axi_wr(CIC_OFF_PEN2, 8'hFF);
		rd_chk("pen2", CIC_OFF_PEN2, CIC_IMPL_P2);
		axi_wr(CIC_OFF_CORE, 8'h80);
		u_src.pulse({10'h0, 24'hFFFFFF});
		settle();
		chk("irq grp", 32'h0, {31'h0, irq});
		rd_chk("pfl3", CIC_OFF_PFL3, CIC_IMPL_P3);
		axi_wr(CIC_OFF_CORE, 8'hC0);
		settle();
		chk("irq grp", 32'h1, {31'h0, irq});
	endtask
	// second reset in mid-run with enables and flags set: irq, the core byte and pfl3 must come back cleared
	task automatic t_rerst();
		@(posedge mclk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'h0;
		chk("irq rst", 32'h0, {31'h0, irq});
		rd_chk("core", CIC_OFF_CORE, 8'h00);
		rd_chk("pfl3", CIC_OFF_PFL3, 8'h00);
	endtask
	initial
	begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'h0;
		t_reset();
		t_flags();
		t_src();
		t_periph();
		t_rerst();
		report_and_stop();
	end
	// watchdog: the run needs well under 4000 cycles
	initial
	begin
		#100000;
		error_cnt++;
		report_and_stop();
	end
endmodule // test_core_interrupt_control
bind cic_core cic_chk #(.PIN_W(PIN_W)) u_chk (.*);

// ===== verilog/cic_core.sv
// core interrupt control: global, group and source enables, sticky flags, request to the core
// assumes single clock mclk, event inputs are one-cycle pulses synchronous to mclk
// Notes on behaviour
// [R1] global enable bit 7 set allows all active interrupts; clear blocks all
// [R2] peripheral group enable bit 6 gates every peripheral interrupt
// [R3] bit 5 enables the timer overflow interrupt
// [R4] bit 4 enables the external pin interrupt
// [R5] bit 3 enables the pin-change interrupt
// [R6] bit 2 reads one after the timer has overflowed
// [R7] bit 1 reads one after the external pin event
// [R8] bit 0 reads one while any pin-change flag is set
// [R9] pin-change summary is read-only; clears when all per-pin flags are cleared
// [R10] flags set on their event regardless of any enable
// [R11] software should clear a flag before enabling its interrupt
// [R12] all core control bits reset to zero on every reset
// [R13] unimplemented peripheral enable and flag bits read as zero
// [R14] request the core only when global enable and an enabled flag, peripherals need group enable
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
module cic_core
	import cic_pkg::*;
#(
	parameter int PIN_W = 8
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	// axi4-lite slave
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// event sources
	input wire logic timer_overflow_evt,
	input wire logic external_pin_evt,
	input wire logic [PIN_W-1:0] pin_change_evt,
	input wire logic [7:0] periph_evt_one,
	input wire logic [7:0] periph_evt_two,
	input wire logic [7:0] periph_evt_three,
	// request to the core interrupt entry
	output logic irq
);
	// core control: enables in bits 7 to 3, flags in bits 2 and 1; bit 0 is derived
	logic [4:0] core_ctl_ff;
	logic [4:0] nxt_core_ctl;
	logic tof_ff;
	logic nxt_tof;
	logic exf_ff;
	logic nxt_exf;
	logic [PIN_W-1:0] per_pin_change_flags_ff;
	logic [PIN_W-1:0] nxt_per_pin;
	// peripheral enables and flags, unimplemented bits held at zero
	logic [7:0] pen1_ff;
	logic [7:0] nxt_pen1;
	logic [7:0] pen2_ff;
	logic [7:0] nxt_pen2;
	logic [7:0] pen3_ff;
	logic [7:0] nxt_pen3;
	logic [7:0] pfl1_ff;
	logic [7:0] nxt_pfl1;
	logic [7:0] pfl2_ff;
	logic [7:0] nxt_pfl2;
	logic [7:0] pfl3_ff;
	logic [7:0] nxt_pfl3;
	// request register so irq leaves straight from a flip-flop
	logic irq_ff;
	logic nxt_irq;

	// write path state
	cic_wstate_e wst_ff;
	cic_wstate_e nxt_wst;
	logic aw_have_ff;
	logic nxt_aw_have;
	logic w_have_ff;
	logic nxt_w_have;
	cic_wreq_s wreq_ff;
	cic_wreq_s nxt_wreq;
	logic awready_ff;
	logic nxt_awready;
	logic wready_ff;
	logic nxt_wready;
	logic [1:0] bresp_ff;
	logic [1:0] nxt_bresp;
	logic bvalid_ff;
	logic nxt_bvalid;

	// read path state
	logic arready_ff;
	logic nxt_arready;
	logic rvalid_ff;
	logic nxt_rvalid;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [1:0] rresp_ff;
	logic [1:0] nxt_rresp;

	// shared glue between the bus side and the register file
	logic do_write;
	logic [7:0] core_byte;
	logic pcf;

	// merge a masked byte write into a register, keeping unimplemented bits at zero
	function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] d,
		input logic en, input logic [7:0] impl);
		wr_byte = (en ? d : old) & impl;
	endfunction

	// address decode used by both read and write paths
	function automatic logic known_addr(input logic [4:0] a);
		known_addr = (a[1:0] == 2'h0);
	endfunction

	// any flag of one peripheral pair that is both set and enabled
	function automatic logic group_hit(input logic [7:0] en, input logic [7:0] fl);
		group_hit = |(en & fl);
	endfunction

	// core byte as software sees it; the summary is only ever the or of the per-pin flags
	assign pcf = |per_pin_change_flags_ff; // [R8] [R9]
	assign core_byte = {core_ctl_ff, tof_ff, exf_ff, pcf}; // [R6] [R7] [R8]
	assign do_write = (wst_ff == CIC_W_IDLE) && aw_have_ff && w_have_ff;

	// write channel capture: address and data accepted in either order
	always_comb
	begin
		nxt_wst = wst_ff;
		nxt_aw_have = aw_have_ff;
		nxt_w_have = w_have_ff;
		nxt_wreq = wreq_ff;
		nxt_awready = 1'b0;
		nxt_wready = 1'b0;
		nxt_bresp = bresp_ff;
		nxt_bvalid = bvalid_ff;
		if (s_axi_awvalid && awready_ff)
		begin
			nxt_aw_have = 1'b1;
			nxt_wreq.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff)
		begin
			nxt_w_have = 1'b1;
			nxt_wreq.data = s_axi_wdata;
			nxt_wreq.strb = s_axi_wstrb;
		end
		// an aligned offset outside the map still answers okay and changes nothing
		case (wst_ff)
			CIC_W_IDLE:
			begin
				// ready is a one-cycle pulse so a held valid is taken once only
				nxt_awready = !aw_have_ff && !awready_ff && s_axi_awvalid;
				nxt_wready = !w_have_ff && !wready_ff && s_axi_wvalid;
				if (do_write)
				begin
					nxt_aw_have = 1'b0;
					nxt_w_have = 1'b0;
					nxt_bvalid = 1'b1;
					nxt_bresp = known_addr(wreq_ff.addr) ? CIC_RESP_OKAY : CIC_RESP_SLVERR;
					nxt_wst = CIC_W_RESP;
				end
			end
			CIC_W_RESP:
			begin
				if (s_axi_bready)
				begin
					nxt_bvalid = 1'b0;
					nxt_wst = CIC_W_IDLE;
				end
			end
			default:
			begin
				nxt_wst = CIC_W_IDLE;
			end
		endcase
	end

	// write path registers; reset leaves both write channels idle
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wst_ff <= CIC_W_IDLE;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			wreq_ff <= '0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bresp_ff <= CIC_RESP_OKAY;
			bvalid_ff <= 1'b0;
		end
		else
		begin
			wst_ff <= nxt_wst;
			aw_have_ff <= nxt_aw_have;
			w_have_ff <= nxt_w_have;
			wreq_ff <= nxt_wreq;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bresp_ff <= nxt_bresp;
			bvalid_ff <= nxt_bvalid;
		end
	end

	// register file: enables from software, flags set by events; set wins over a clear
	always_comb
	begin
		logic we;
		logic [4:0] a;
		logic [7:0] d;
		we = do_write && wreq_ff.strb[0];
		a = wreq_ff.addr;
		d = wreq_ff.data[7:0];
		nxt_core_ctl = core_ctl_ff;
		nxt_tof = tof_ff;
		nxt_exf = exf_ff;
		nxt_per_pin = per_pin_change_flags_ff;
		nxt_pen1 = pen1_ff;
		nxt_pen2 = pen2_ff;
		nxt_pen3 = pen3_ff;
		nxt_pfl1 = pfl1_ff;
		nxt_pfl2 = pfl2_ff;
		nxt_pfl3 = pfl3_ff;
		if (we && a == CIC_OFF_CORE)
		begin
			nxt_core_ctl = d[CIC_B_GIE:CIC_B_PCE]; // [R1] [R2] [R3] [R4] [R5]
			nxt_tof = d[CIC_B_TOF];
			nxt_exf = d[CIC_B_EXF];
			// summary bit ignores writes
		end
		// peripheral bytes: a write replaces the implemented bits only
		nxt_pen1 = wr_byte(pen1_ff, d, we && a == CIC_OFF_PEN1, CIC_IMPL_P1); // [R13]
		nxt_pen2 = wr_byte(pen2_ff, d, we && a == CIC_OFF_PEN2, CIC_IMPL_P2); // [R13]
		nxt_pen3 = wr_byte(pen3_ff, d, we && a == CIC_OFF_PEN3, CIC_IMPL_P3); // [R13]
		nxt_pfl1 = wr_byte(pfl1_ff, d, we && a == CIC_OFF_PFL1, CIC_IMPL_P1);
		nxt_pfl2 = wr_byte(pfl2_ff, d, we && a == CIC_OFF_PFL2, CIC_IMPL_P2);
		nxt_pfl3 = wr_byte(pfl3_ff, d, we && a == CIC_OFF_PFL3, CIC_IMPL_P3);
		// apart from reset, writing zero to the per-pin flags is the only way to drop the summary bit
		if (we && a == CIC_OFF_PINF)
		begin
			nxt_per_pin = d[PIN_W-1:0]; // [R9]
		end
		// events set flags whatever the enables say
		nxt_tof = nxt_tof | timer_overflow_evt; // [R10] [R6]
		nxt_exf = nxt_exf | external_pin_evt; // [R10] [R7]
		nxt_per_pin = nxt_per_pin | pin_change_evt; // [R10]
		nxt_pfl1 = nxt_pfl1 | (periph_evt_one & CIC_IMPL_P1); // [R10] [R13]
		nxt_pfl2 = nxt_pfl2 | (periph_evt_two & CIC_IMPL_P2); // [R10] [R13]
		nxt_pfl3 = nxt_pfl3 | (periph_evt_three & CIC_IMPL_P3); // [R10] [R13]
	end

	// interrupt request: global gate, then core sources or gated peripheral group
	always_comb
	begin
		logic core_hit;
		logic peri_hit;
		core_hit = (core_byte[CIC_B_TOE] & core_byte[CIC_B_TOF]) // [R3]
			| (core_byte[CIC_B_EXE] & core_byte[CIC_B_EXF]) // [R4]
			| (core_byte[CIC_B_PCE] & core_byte[CIC_B_PCF]); // [R5]
		peri_hit = core_byte[CIC_B_PGE] // [R2]
			& (group_hit(pen1_ff, pfl1_ff) | group_hit(pen2_ff, pfl2_ff) | group_hit(pen3_ff, pfl3_ff));
		// the group gate leaves the core sources alone; only the global gate covers both
		nxt_irq = core_byte[CIC_B_GIE] & (core_hit | peri_hit); // [R1] [R14]
	end

	// register state; every reset clears the whole core control byte
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			core_ctl_ff <= CIC_RST_BYTE[7:3]; // [R12]
			tof_ff <= 1'b0; // [R12]
			exf_ff <= 1'b0; // [R12]
			per_pin_change_flags_ff <= '0;
			pen1_ff <= CIC_RST_BYTE;
			pen2_ff <= CIC_RST_BYTE;
			pen3_ff <= CIC_RST_BYTE;
			pfl1_ff <= CIC_RST_BYTE;
			pfl2_ff <= CIC_RST_BYTE;
			pfl3_ff <= CIC_RST_BYTE;
			irq_ff <= 1'b0;
		end
		else
		begin
			core_ctl_ff <= nxt_core_ctl;
			tof_ff <= nxt_tof;
			exf_ff <= nxt_exf;
			per_pin_change_flags_ff <= nxt_per_pin;
			pen1_ff <= nxt_pen1;
			pen2_ff <= nxt_pen2;
			pen3_ff <= nxt_pen3;
			pfl1_ff <= nxt_pfl1;
			pfl2_ff <= nxt_pfl2;
			pfl3_ff <= nxt_pfl3;
			irq_ff <= nxt_irq;
		end
	end

	// read path: one read at a time, arready pulses, data held until rready
	always_comb
	begin
		logic [7:0] rb;
		rb = 8'h00;
		case (s_axi_araddr)
			CIC_OFF_CORE: rb = core_byte;
			CIC_OFF_PEN1: rb = pen1_ff;
			CIC_OFF_PEN2: rb = pen2_ff;
			CIC_OFF_PEN3: rb = pen3_ff;
			CIC_OFF_PFL1: rb = pfl1_ff;
			CIC_OFF_PFL2: rb = pfl2_ff;
			CIC_OFF_PFL3: rb = pfl3_ff;
			CIC_OFF_PINF: rb = 8'(per_pin_change_flags_ff);
			default: rb = 8'h00;
		endcase
		nxt_arready = 1'b0;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (rvalid_ff)
		begin
			if (s_axi_rready)
			begin
				nxt_rvalid = 1'b0;
			end
		end
		else if (s_axi_arvalid && !arready_ff)
		begin
			nxt_arready = 1'b1;
			nxt_rvalid = 1'b1;
			nxt_rdata = {24'h000000, rb};
			nxt_rresp = known_addr(s_axi_araddr) ? CIC_RESP_OKAY : CIC_RESP_SLVERR;
		end
	end

	// read path registers
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= CIC_RESP_OKAY;
		end
		else
		begin
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	// every output comes straight from its flip-flop
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign irq = irq_ff;
endmodule // cic_core

// ===== verilog/cic_pkg.sv
// package for the core interrupt control block: register map, field positions, reset values
// assumes a 32-bit AXI4-Lite master and word-aligned registers
package cic_pkg;
	// register byte offsets
	localparam logic [4:0] CIC_OFF_CORE = 5'h00;
	localparam logic [4:0] CIC_OFF_PEN1 = 5'h04;
	localparam logic [4:0] CIC_OFF_PEN2 = 5'h08;
	localparam logic [4:0] CIC_OFF_PEN3 = 5'h0C;
	localparam logic [4:0] CIC_OFF_PFL1 = 5'h10;
	localparam logic [4:0] CIC_OFF_PFL2 = 5'h14;
	localparam logic [4:0] CIC_OFF_PFL3 = 5'h18;
	localparam logic [4:0] CIC_OFF_PINF = 5'h1C;
	// core control field positions
	localparam int CIC_B_GIE = 7;
	localparam int CIC_B_PGE = 6;
	localparam int CIC_B_TOE = 5;
	localparam int CIC_B_EXE = 4;
	localparam int CIC_B_PCE = 3;
	localparam int CIC_B_TOF = 2;
	localparam int CIC_B_EXF = 1;
	localparam int CIC_B_PCF = 0;
	// reset values
	localparam logic [7:0] CIC_RST_BYTE = 8'h00;
	// implemented bits of the peripheral enable and flag registers
	localparam logic [7:0] CIC_IMPL_P1 = 8'hFF;
	localparam logic [7:0] CIC_IMPL_P2 = 8'hFD;
	localparam logic [7:0] CIC_IMPL_P3 = 8'h7A;
	// axi responses
	localparam logic [1:0] CIC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CIC_RESP_SLVERR = 2'h2;
	// write request gathered from the two write channels
	typedef struct packed {
		logic [4:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} cic_wreq_s;
	typedef enum logic [1:0] {
		CIC_W_IDLE = 2'b00,
		CIC_W_RESP = 2'b01
	} cic_wstate_e;
endpackage : cic_pkg
